// >>> tws_map.vh
/*
 * register offsets, field positions, reset values and timing counts of the
 * two-wire slave flag block; assumes an 8-bit register port on ref_clk.
 */
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define TWS_ADDR_CTRL     4'h0
`define TWS_ADDR_STATUS   4'h1
`define TWS_ADDR_CMD      4'h2
`define TWS_ADDR_IRQ_STAT 4'h3
`define TWS_ADDR_IRQ_CLR  4'h4
`define TWS_ADDR_IRQ_EN   4'h5
`define TWS_ADDR_DATA     4'h6
`define TWS_ADDR_OWNADDR  4'h7

// ****************************************
// control fields
// ****************************************
`define TWS_CTRL_EN       0
`define TWS_CTRL_TOEN     1
`define TWS_CTRL_RESET    8'h00

// ****************************************
// status fields
// ****************************************
`define TWS_ST_ADDRESS_STOP_IRQ_FLAG       0
`define TWS_ST_DIF        1
`define TWS_ST_COLL       2
`define TWS_ST_HOLD       3
`define TWS_ST_BUS_LO     4
`define TWS_ST_AP         6
`define TWS_ST_DIR        7

// ****************************************
// bus condition encodings
// ****************************************
`define TWS_BUS_UNKNOWN   2'h0
`define TWS_BUS_IDLE      2'h1
`define TWS_BUS_BUSY      2'h3

// ****************************************
// interrupt event bits
// ****************************************
`define TWS_EV_ADDR       0
`define TWS_EV_STOP       1
`define TWS_EV_DATA       2
`define TWS_EV_COLL       3
`define TWS_EV_TOUT       4
`define TWS_EV_DROP       5
`define TWS_EV_W          6

// ****************************************
// commands and timing
// ****************************************
`define TWS_CMD_NONE      2'h0
`define TWS_CMD_COMPLETE  2'h3
`define TWS_CMD_RESPOND   2'h2
`define TWS_TIMEOUT_US    100
`define TWS_CLK_MHZ       50
`define TWS_TIMEOUT_CYC   (`TWS_TIMEOUT_US * `TWS_CLK_MHZ)

`endif

// >>> tws_sync.v
/*
 * two-flop synchroniser for one level from outside ref_clk;
 * assumes the input is a pin level.
 */
`timescale 1ns/1ns
module tws_sync (
	input  wire ref_clk,
	input  wire resetn,
	input  wire asyncIn,
	output wire syncOut
);
	reg metaQ;
	reg syncQ;

	// ****************************************
	// two stages, idle high
	// ****************************************
	always @(posedge ref_clk) begin
		if (!resetn) begin
			metaQ <= 1'b1;
			syncQ <= 1'b1;
		end else begin
			metaQ <= asyncIn;
			syncQ <= metaQ;
		end
	end

	assign syncOut = syncQ;
endmodule

// >>> tws_slave.v
/*
 * two-wire slave: start/stop detection, address match, byte shift,
 * flag and clock-hold behaviour, register port and interrupt.
 * assumes scl/sda pins arrive asynchronously; open-drain outputs via enable.
 */
`timescale 1ns/1ns
`include "tws_map.vh"
module tws_slave #(
	parameter TIMEOUT_CYC = `TWS_TIMEOUT_CYC
) (
	input  wire       ref_clk,
	input  wire       resetn,
	input  wire [3:0] regAddr,
	input  wire [7:0] regWrData,
	input  wire       regWr,
	input  wire       regRd,
	output reg  [7:0] regRdData,
	input  wire       sclIn,
	input  wire       sdaIn,
	output reg        sclOe_n,
	output reg        sdaOe_n,
	output reg        irq
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_AACK = 3'h2;
	localparam ST_DATA = 3'h3;
	localparam ST_DACK = 3'h4;
	localparam ST_WAIT = 3'h5;

	wire       scl;
	wire       sda;
	reg        sclPrev_q;
	reg        sdaPrev_q;
	reg  [2:0] state_q;
	reg  [7:0] ctrl_q;
	reg  [6:0] ownAddr_q;
	reg  [7:0] shift_q;
	reg  [7:0] txData_q;
	reg  [7:0] rxData_q;
	reg  [3:0] bitCnt_q;
	reg        address_stop_irq_flag_q;
	reg        ap_q;
	reg        dif_q;
	reg        difClr_q;
	reg        coll_q;
	reg        hold_q;
	reg        dir_q;
	reg        ackOut_q;
	reg  [1:0] busCond_q;
	reg  [`TWS_EV_W-1:0] evStat_q;
	reg  [`TWS_EV_W-1:0] evEn_q;
	reg  [31:0] toCnt_q;

	tws_sync uSyncScl (.ref_clk(ref_clk), .resetn(resetn), .asyncIn(sclIn), .syncOut(scl));
	tws_sync uSyncSda (.ref_clk(ref_clk), .resetn(resetn), .asyncIn(sdaIn), .syncOut(sda));

	function isWrite;
		input [3:0] a;
		input [3:0] which;
		begin
			isWrite = regWr && (a == which);
		end
	endfunction

	// ****************************************
	// bus events
	// ****************************************
	wire enabled   = ctrl_q[`TWS_CTRL_EN];
	wire sclRise   = scl && !sclPrev_q;
	wire sclFall   = !scl && sclPrev_q;
	wire startDet  = scl && sclPrev_q && sdaPrev_q && !sda;
	wire stopDet   = scl && sclPrev_q && !sdaPrev_q && sda;
	wire toHit     = ctrl_q[`TWS_CTRL_TOEN] && (toCnt_q >= TIMEOUT_CYC - 1);
	wire repStart  = startDet && (busCond_q == `TWS_BUS_BUSY);
	wire dropStart = startDet && toHit;
	wire addrMatch = (state_q == ST_ADDR) && sclRise && (bitCnt_q == 4'h7)
		&& (shift_q[6:0] == ownAddr_q);
	wire apifClr   = isWrite(regAddr, `TWS_ADDR_STATUS) && regWrData[`TWS_ST_ADDRESS_STOP_IRQ_FLAG];
	wire cmdWr     = isWrite(regAddr, `TWS_ADDR_CMD);
	wire cmdDone   = cmdWr && (regWrData[1:0] == `TWS_CMD_COMPLETE);
	wire cmdResp   = cmdWr && (regWrData[1:0] == `TWS_CMD_RESPOND);
	wire byteDone  = (state_q == ST_DATA) && sclFall && (bitCnt_q == 4'h8);
	wire addrSet   = addrMatch && enabled;
	wire stopSet   = stopDet && (state_q != ST_IDLE);
	wire [`TWS_EV_W-1:0] evNow;

	assign evNow = {dropStart, toHit && busCond_q == `TWS_BUS_BUSY,
		coll_q && cmdResp, byteDone, stopSet, addrSet};

	// ****************************************
	// slave sequencing
	// ****************************************
	always @(posedge ref_clk) begin
		if (!resetn) begin
			state_q   <= ST_IDLE;
			shift_q   <= 8'h00;
			rxData_q  <= 8'h00;
			bitCnt_q  <= 4'h0;
			dir_q     <= 1'b0;
			ackOut_q  <= 1'b0;
			busCond_q <= `TWS_BUS_UNKNOWN;
			toCnt_q   <= 32'h0;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= scl;
			sdaPrev_q <= sda;
			toCnt_q   <= (startDet || stopDet || sclFall || toHit) ? 32'h0 : toCnt_q + 32'h1;
			if (stopDet || toHit)
				busCond_q <= `TWS_BUS_IDLE;
			else if (startDet)
				busCond_q <= `TWS_BUS_BUSY;
			if (!enabled || stopDet || dropStart || toHit) begin
				state_q  <= ST_IDLE;
				ackOut_q <= 1'b0;
			end else if (startDet) begin
				state_q  <= ST_ADDR;
				bitCnt_q <= 4'h0;
				ackOut_q <= 1'b0;
			end else begin
				case (state_q)
				ST_ADDR: if (sclRise) begin
					shift_q  <= {shift_q[6:0], sda};
					bitCnt_q <= bitCnt_q + 4'h1;
					if (bitCnt_q == 4'h7) begin
						dir_q   <= sda;
						state_q <= (shift_q[6:0] == ownAddr_q) ? ST_WAIT : ST_IDLE;
					end
				end
				ST_WAIT: begin
					// ack goes out while scl is low, before scl is let go
					if (!scl)
						ackOut_q <= 1'b1;
					if (!hold_q && ackOut_q)
						state_q <= ST_AACK;
				end
				ST_AACK: if (sclFall) begin
					ackOut_q <= dir_q ? !txData_q[7] : 1'b0;
					shift_q  <= txData_q;
					bitCnt_q <= 4'h0;
					state_q  <= ST_DATA;
				end
				ST_DATA: begin
					if (sclRise) begin
						shift_q  <= {shift_q[6:0], sda};
						bitCnt_q <= bitCnt_q + 4'h1;
					end
					if (sclFall && dir_q && bitCnt_q < 4'h7)
						ackOut_q <= !shift_q[7];
					if (byteDone) begin
						ackOut_q <= 1'b0;
						rxData_q <= shift_q;
						state_q  <= ST_DACK;
					end
				end
				ST_DACK: begin
					ackOut_q <= !dir_q;
					if (!hold_q)
						state_q <= ST_AACK;
				end
				default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// flags and clock hold
	// ****************************************
	always @(posedge ref_clk) begin
		if (!resetn) begin
			address_stop_irq_flag_q   <= 1'b0;
			ap_q     <= 1'b0;
			dif_q    <= 1'b0;
			difClr_q <= 1'b0;
			coll_q   <= 1'b0;
			hold_q   <= 1'b0;
		end else begin
			if (addrSet || stopSet) begin
				address_stop_irq_flag_q <= 1'b1;
				ap_q   <= addrSet;
			end else if (apifClr)
				address_stop_irq_flag_q <= 1'b0;
			if (addrSet)
				hold_q <= 1'b1;
			else if (apifClr || byteDone == 1'b0 && difClr_q)
				hold_q <= 1'b0;
			else if (byteDone)
				hold_q <= 1'b1;
			difClr_q <= cmdDone;
			if (byteDone)
				dif_q <= 1'b1;
			else if (difClr_q)
				dif_q <= 1'b0;
			if (cmdResp && state_q != ST_DATA && busCond_q == `TWS_BUS_BUSY && dir_q)
				coll_q <= 1'b1;
			else if (startDet && !repStart)
				coll_q <= 1'b0;
			else if (isWrite(regAddr, `TWS_ADDR_STATUS) && regWrData[`TWS_ST_COLL])
				coll_q <= 1'b0;
		end
	end

	// ****************************************
	// register port and interrupt
	// ****************************************
	always @(posedge ref_clk) begin
		if (!resetn) begin
			ctrl_q    <= `TWS_CTRL_RESET;
			ownAddr_q <= 7'h00;
			txData_q  <= 8'h00;
			evStat_q  <= {`TWS_EV_W{1'b0}};
			evEn_q    <= {`TWS_EV_W{1'b0}};
			regRdData <= 8'h00;
			irq       <= 1'b0;
			sclOe_n   <= 1'b1;
			sdaOe_n   <= 1'b1;
		end else begin
			if (isWrite(regAddr, `TWS_ADDR_CTRL))
				ctrl_q <= regWrData;
			if (isWrite(regAddr, `TWS_ADDR_OWNADDR))
				ownAddr_q <= regWrData[6:0];
			if (isWrite(regAddr, `TWS_ADDR_DATA))
				txData_q <= regWrData;
			if (isWrite(regAddr, `TWS_ADDR_IRQ_EN))
				evEn_q <= regWrData[`TWS_EV_W-1:0];
			evStat_q <= evNow | (evStat_q & ~({`TWS_EV_W{isWrite(regAddr,
				`TWS_ADDR_IRQ_CLR)}} & regWrData[`TWS_EV_W-1:0]));
			irq <= |(evStat_q & evEn_q);
			// scl stays low until the ack level is on sda
			sclOe_n <= !(hold_q || (state_q == ST_WAIT && !ackOut_q)
				|| (state_q == ST_DACK && ackOut_q == dir_q));
			sdaOe_n <= !ackOut_q;
			regRdData <= 8'h00;
			if (regRd) begin
				case (regAddr)
				`TWS_ADDR_CTRL:     regRdData <= ctrl_q;
				`TWS_ADDR_STATUS:   regRdData <= {dir_q, ap_q, busCond_q, hold_q,
					coll_q, dif_q, address_stop_irq_flag_q};
				`TWS_ADDR_IRQ_STAT: regRdData <= {2'h0, evStat_q};
				`TWS_ADDR_IRQ_EN:   regRdData <= {2'h0, evEn_q};
				`TWS_ADDR_DATA:     regRdData <= rxData_q;
				`TWS_ADDR_OWNADDR:  regRdData <= {1'b0, ownAddr_q};
				default:            regRdData <= 8'h00;
				endcase
			end
		end
	end
endmodule

// >>> tws_slave_properties.sv
/* port timing checks for tws_slave; bound to every instance. */
`timescale 1ns/1ns
module tws_slave_properties #(
	parameter TIMEOUT_CYC = 5000
) (
	input wire       ref_clk,
	input wire       resetn,
	input wire [3:0] regAddr,
	input wire [7:0] regWrData,
	input wire       regWr,
	input wire       regRd,
	input wire [7:0] regRdData,
	input wire       sclOe_n,
	input wire       irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence sStat;
		regRd && regAddr == 4'h1;
	endsequence
	sequence sDone;
		regWr && regAddr == 4'h2 && regWrData[1:0] == 2'h3;
	endsequence
	a_read_idle_zero: assert property (!regRd |=> regRdData == 8'h00)
		else $error("read data outside read");
	a_unmapped_zero: assert property (regRd && regAddr[3] |=> regRdData == 8'h00)
		else $error("unmapped read");
	a_hold_release: assert property (regWr && regAddr == 4'h1 && regWrData[0] && !sclOe_n
		|-> ##[1:3] sclOe_n) else $error("hold kept");
	a_data_flag_late: assert property (sStat ##1 (regRdData[1] and sDone) ##1 sStat ##1 sStat
		|-> regRdData[1] ##1 !regRdData[1]) else $error("data flag timing");
	a_irq_masked: assert property (regWr && regAddr == 4'h5 && regWrData == 8'h00 |-> ##2 !irq)
		else $error("irq not masked");
	a_irq_cleared: assert property (regWr && regAddr == 4'h4 && regWrData == 8'hff |-> ##2 !irq)
		else $error("irq not cleared");
endmodule
bind tws_slave tws_slave_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.ref_clk(ref_clk),
	.resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
	.regRd(regRd), .regRdData(regRdData), .sclOe_n(sclOe_n), .irq(irq));

// >>> tws_i2c_master.sv
/* behavioural bus master; lines resolved outside with pull-ups. */
`timescale 1ns/1ns
module tws_i2c_master (
	input  wire sclLine,
	input  wire sdaLine,
	output reg  sclDrv,
	output reg  sdaDrv,
	output reg  ackSeen
);
	initial begin
		sclDrv = 1'b1;
		sdaDrv = 1'b1;
		ackSeen = 1'b0;
	end
	task start;
		sdaDrv = 1'b1;
		#40 sclDrv = 1'b1;
		#80 sdaDrv = 0;
		#80 sclDrv = 0;
	endtask
	task stop;
		#40 sdaDrv = 1'b0;
		#80 sclDrv = 1'b1;
		#80 sdaDrv = 1'b1;
	endtask
	// one bit, waits out clock stretching
	task bitOut(input logic b, input int lowNs);
		#40 sdaDrv = b;
		#(lowNs) sclDrv = 1'b1;
		wait (sclLine);
		#40 ackSeen = !sdaLine;
		#40 sclDrv = 1'b0;
	endtask
	task sendByte(input logic [7:0] d);
		int i;
		for (i = 7; i >= 0; i--) bitOut(d[i], 40);
		bitOut(1'b1, 200);
	endtask
endmodule

// >>> tb_top.sv
/* self-checking bench for tws_slave; master model on the two-wire side. */
`timescale 1ns/1ns
module tb_top;
	reg         ref_clk;
	reg         resetn;
	reg  [3:0]  regAddr;
	reg  [7:0]  regWrData;
	reg         regWr;
	reg         regRd;
	wire [7:0]  regRdData;
	wire        sclOe_n, sdaOe_n, irq, sclDrv, sdaDrv, ackSeen;
	wire        sclLine = sclDrv & sclOe_n;
	wire        sdaLine = sdaDrv & sdaOe_n;
	int         miscompares = 0;
	int         n_tests = 0;
	tws_slave #(.TIMEOUT_CYC(50)) i_tws_slave (.ref_clk(ref_clk), .resetn(resetn),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .sclIn(sclLine), .sdaIn(sdaLine), .sclOe_n(sclOe_n),
		.sdaOe_n(sdaOe_n), .irq(irq));
	tws_i2c_master i_tws_i2c_master (.sclLine(sclLine), .sdaLine(sdaLine),
		.sclDrv(sclDrv), .sdaDrv(sdaDrv), .ackSeen(ackSeen));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %h, not %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		if (miscompares == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 check(regRdData & m, e);
	endtask
	task waitHold;
		int i;
		for (i = 0; i < 3000 && sclOe_n !== 1'b0; i++) @(posedge ref_clk);
		check({7'h00, sclOe_n}, 8'h00);
	endtask
	task t_reset;
		check({7'h00, irq}, 8'h00);
		rd(4'h1, 8'hff, 8'h00);
		rd(4'hf, 8'hff, 8'h00);
	endtask
	task t_address;
		wr(4'h7, 8'h2a);
		wr(4'h0, 8'h01);
		wr(4'h5, 8'h01);
		fork
			begin
				i_tws_i2c_master.start();
				i_tws_i2c_master.sendByte(8'h54);
			end
			begin
				waitHold;
				rd(4'h1, 8'hff, 8'h79);
				check({7'h00, irq}, 8'h01);
				wr(4'h5, 8'h00);
				rd(4'h3, 8'hff, 8'h01);
				check({7'h00, irq}, 8'h00);
				wr(4'h5, 8'h01);
				rd(4'h4, 8'hff, 8'h00);
				check({7'h00, irq}, 8'h01);
				wr(4'h4, 8'hff);
				rd(4'h3, 8'hff, 8'h00);
				wr(4'h1, 8'h05);
				rd(4'h1, 8'h08, 8'h00);
			end
		join
		check({7'h00, ackSeen}, 8'h01);
	endtask
	task t_data;
		fork
			i_tws_i2c_master.sendByte(8'ha5);
			begin
				waitHold;
				@(posedge ref_clk) regRd <= 1'b1;
				regAddr <= 4'h1;
				@(posedge ref_clk) regRd <= 1'b0;
				regWr <= 1'b1;
				regAddr <= 4'h2;
				regWrData <= 8'h03;
				#1 check(regRdData & 8'h02, 8'h02);
				@(posedge ref_clk) regWr <= 1'b0;
				regRd <= 1'b1;
				regAddr <= 4'h1;
				@(posedge ref_clk);
				#1 check(regRdData & 8'h02, 8'h02);
				@(posedge ref_clk) regRd <= 1'b0;
				#1 check(regRdData & 8'h02, 8'h00);
			end
		join
		i_tws_i2c_master.stop();
		repeat (10) @(posedge ref_clk);
		rd(4'h1, 8'h30, 8'h10);
		rd(4'h6, 8'hff, 8'ha5);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		resetn = 1'b0;
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		t_reset;
		t_address;
		t_data;
		end_of_test;
	end
	initial begin
		#1000000;
		miscompares++;
		end_of_test;
	end
endmodule
